/* hw/rss_exec.sv */
// Execution block for rotate, literal subtract and sleep, with a Wishbone register slave.
`timescale 1ns/1ps
module rss_exec
  import rss_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADR_W-1:0]  adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic              wake_i,
  output logic                   osc_run_o,
  output logic                   asleep_o
);

  rss_state_t         state;
  logic [7:0]         acc;
  logic [7:0]         file_mem [FILE_COUNT];
  logic               carry;
  logic               nibble_carry_flag;
  logic               zero;
  logic               timeout_status_flag;
  logic               powerdown_status_flag;
  logic [7:0]         watchdog_counter;
  logic [7:0]         watchdog_prescaler;
  logic [2:0]         wake_sync;
  logic               req;
  logic               wr_stb;
  logic               exec_go;
  logic [OP_W-1:0]    cmd_op;
  logic [FILE_AW-1:0] cmd_adr;
  logic               cmd_dest;
  logic [7:0]         cmd_lit;
  logic [7:0]         alu_result;
  logic               alu_carry;
  logic               alu_nibble;
  logic               alu_zero;
  logic               is_rotate;
  logic               is_subtract;
  logic               is_sleep;
  logic [31:0]        next_dat;

  // True when the bus address selects the register at the given offset.
  function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
    reg_hit = (adr[ADR_W-1:WORD_LSB] == ofs[ADR_W-1:WORD_LSB]);
  endfunction

  // True when the bus address falls inside the data-memory window.
  function automatic logic file_hit(input logic [ADR_W-1:0] adr);
    file_hit = (adr[ADR_W-1:FILE_SEL_LSB] == FILE_SEL_CODE);
  endfunction

  // The answer comes one cycle after the request is presented and lasts one cycle.
  assign req    = cyc_i & stb_i;
  assign wr_stb = req & ack_o & we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req & ~ack_o;
    end
  end

  // A command is taken only when both low byte lanes are written and the core runs.
  assign cmd_op   = dat_i[CMD_OP_LSB +: OP_W];
  assign cmd_adr  = dat_i[CMD_ADR_LSB +: FILE_AW];
  assign cmd_dest = dat_i[CMD_DEST_BIT];
  assign cmd_lit  = dat_i[CMD_LIT_LSB +: 8];
  assign exec_go  = wr_stb & reg_hit(adr_i, OFS_CMD) & sel_i[0] & sel_i[1]
                    & (state == RSS_ST_RUN);

  assign is_rotate   = exec_go & ((cmd_op == RSS_OP_ROTATE_LEFT_THROUGH_CARRY)
                                  | (cmd_op == RSS_OP_ROTATE_RIGHT_THROUGH_CARRY));
  assign is_subtract = exec_go & (cmd_op == RSS_OP_LITERAL_MINUS_ACCUMULATOR);
  assign is_sleep    = exec_go & (cmd_op == RSS_OP_SLEEP);

  rss_alu u_alu (
    .op_i                (cmd_op),
    .file_i              (file_mem[cmd_adr]),
    .acc_i               (acc),
    .literal_i           (cmd_lit),
    .carry_i             (carry),
    .result_o            (alu_result),
    .carry_o             (alu_carry),
    .nibble_carry_flag_o (alu_nibble),
    .zero_o              (alu_zero)
  );

  // Wake input from a pin: three stages, a high level counts when stages two and three both show it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_sync <= 3'h0;
    end else begin
      wake_sync <= {wake_sync[1:0], wake_i};
    end
  end

  // Core state: sleep halts commands until a synchronised wake level arrives.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RSS_ST_RUN;
    end else begin
      unique case (state)
        RSS_ST_RUN: begin
          if (is_sleep) begin
            state <= RSS_ST_SLEEP;
          end
        end
        RSS_ST_SLEEP: begin
          if (wake_sync[1] & wake_sync[2]) begin
            state <= RSS_ST_RUN;
          end
        end
        default: begin
          state <= RSS_ST_RUN;
        end
      endcase
    end
  end

  assign osc_run_o = (state == RSS_ST_RUN);
  assign asleep_o  = (state == RSS_ST_SLEEP);

  // Working accumulator.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= ACC_RST;
    end else if (is_rotate & ~cmd_dest) begin
      acc <= alu_result;
    end else if (is_subtract) begin
      acc <= alu_result;
    end else if (wr_stb & reg_hit(adr_i, OFS_ACC) & sel_i[0]) begin
      acc <= dat_i[7:0];
    end
  end

  // Data-memory registers: rotate write-back or direct bus write, one word per entry.
  genvar gi;
  generate
    for (gi = 0; gi < FILE_COUNT; gi++) begin : g_file
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          file_mem[gi] <= FILE_RST;
        end else if (is_rotate & cmd_dest & (cmd_adr == FILE_AW'(gi))) begin
          file_mem[gi] <= alu_result;
        end else if (wr_stb & file_hit(adr_i) & sel_i[0]
                     & (adr_i[WORD_LSB +: FILE_AW] == FILE_AW'(gi))) begin
          file_mem[gi] <= dat_i[7:0];
        end
      end
    end
  endgenerate

  // Arithmetic flags. Rotates touch only carry; software may write them when idle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry             <= 1'b0;
      nibble_carry_flag <= 1'b0;
      zero              <= 1'b0;
    end else if (is_rotate) begin
      carry <= alu_carry;
    end else if (is_subtract) begin
      carry             <= alu_carry;
      nibble_carry_flag <= alu_nibble;
      zero              <= alu_zero;
    end else if (wr_stb & reg_hit(adr_i, OFS_STATUS) & sel_i[0]) begin
      carry             <= dat_i[ST_CARRY_BIT];
      nibble_carry_flag <= dat_i[ST_NIBBLE_BIT];
      zero              <= dat_i[ST_ZERO_BIT];
    end
  end

  // Time-out and power-down status; both read as one after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_status_flag   <= TIMEOUT_RST;
      powerdown_status_flag <= POWERDOWN_RST;
    end else if (is_sleep) begin
      timeout_status_flag   <= 1'b1;
      powerdown_status_flag <= 1'b0;
    end
  end

  // Watchdog counter and prescaler run while awake; a sleep command clears them and they hold while the oscillator is stopped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      watchdog_prescaler <= PRESC_CLEAR;
      watchdog_counter   <= WDOG_CLEAR;
    end else if (is_sleep) begin
      watchdog_prescaler <= PRESC_CLEAR;
      watchdog_counter   <= WDOG_CLEAR;
    end else if (state == RSS_ST_RUN) begin
      watchdog_prescaler <= watchdog_prescaler + 8'h01;
      if (watchdog_prescaler == PRESC_MAX) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
    end
  end

  // Read mux; unmapped addresses read as zero and are still answered.
  always_comb begin
    next_dat = 32'h0000_0000;
    if (file_hit(adr_i)) begin
      next_dat[7:0] = file_mem[adr_i[WORD_LSB +: FILE_AW]];
    end else if (reg_hit(adr_i, OFS_ACC)) begin
      next_dat[7:0] = acc;
    end else if (reg_hit(adr_i, OFS_STATUS)) begin
      next_dat[ST_CARRY_BIT]     = carry;
      next_dat[ST_NIBBLE_BIT]    = nibble_carry_flag;
      next_dat[ST_ZERO_BIT]      = zero;
      next_dat[ST_POWERDOWN_BIT] = powerdown_status_flag;
      next_dat[ST_TIMEOUT_BIT]   = timeout_status_flag;
    end else if (reg_hit(adr_i, OFS_WDOG)) begin
      next_dat[7:0] = watchdog_counter;
    end else if (reg_hit(adr_i, OFS_PRESC)) begin
      next_dat[7:0] = watchdog_prescaler;
    end else if (reg_hit(adr_i, OFS_STATE)) begin
      next_dat[STATE_ASLEEP_BIT] = (state == RSS_ST_SLEEP);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req & ~ack_o & ~we_i) begin
      dat_o <= next_dat;
    end
  end

endmodule

/* hw/rss_pkg.sv */
// Package with register map, field layout, opcodes and states of the execution block.
package rss_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] OFS_CMD       = 8'h00;
  localparam logic [7:0] OFS_ACC       = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_WDOG      = 8'h0C;
  localparam logic [7:0] OFS_PRESC     = 8'h10;
  localparam logic [7:0] OFS_STATE     = 8'h14;
  localparam logic [7:0] OFS_FILE_BASE = 8'h40;

  // The data-memory window covers sixteen words starting at OFS_FILE_BASE.
  localparam int         ADR_W         = 8;
  localparam int         FILE_AW       = 4;
  localparam int         FILE_COUNT    = 16;
  localparam int         WORD_LSB      = 2;
  localparam int         FILE_SEL_LSB  = 6;
  localparam logic [1:0] FILE_SEL_CODE = 2'h1;

  // Command register fields.
  localparam int CMD_LIT_LSB  = 0;
  localparam int CMD_ADR_LSB  = 8;
  localparam int CMD_DEST_BIT = 12;
  localparam int CMD_OP_LSB   = 13;
  localparam int OP_W         = 3;

  // Status register bit positions.
  localparam int ST_CARRY_BIT     = 0;
  localparam int ST_NIBBLE_BIT    = 1;
  localparam int ST_ZERO_BIT      = 2;
  localparam int ST_POWERDOWN_BIT = 3;
  localparam int ST_TIMEOUT_BIT   = 4;
  localparam int STATE_ASLEEP_BIT = 0;

  // Reset and clear values.
  localparam logic [7:0] ACC_RST       = 8'h00;
  localparam logic [7:0] FILE_RST      = 8'h00;
  localparam logic [7:0] WDOG_CLEAR    = 8'h00;
  localparam logic [7:0] PRESC_CLEAR   = 8'h00;
  localparam logic [7:0] PRESC_MAX     = 8'hFF;
  localparam logic       TIMEOUT_RST   = 1'b1;
  localparam logic       POWERDOWN_RST = 1'b1;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  typedef enum logic [OP_W-1:0] {
    RSS_OP_NONE                      = 3'h0,
    RSS_OP_ROTATE_LEFT_THROUGH_CARRY  = 3'h1,
    RSS_OP_ROTATE_RIGHT_THROUGH_CARRY = 3'h2,
    RSS_OP_LITERAL_MINUS_ACCUMULATOR  = 3'h3,
    RSS_OP_SLEEP                      = 3'h4
  } rss_op_t;

  typedef enum logic [1:0] {
    RSS_ST_RUN   = 2'b01,
    RSS_ST_SLEEP = 2'b10
  } rss_state_t;

endpackage

/* hw/rss_alu.sv */
// Combinational datapath for the two rotates and the literal subtract.
`timescale 1ns/1ps
module rss_alu
  import rss_pkg::*;
(
  input  wire logic [OP_W-1:0] op_i,
  input  wire logic [7:0]      file_i,
  input  wire logic [7:0]      acc_i,
  input  wire logic [7:0]      literal_i,
  input  wire logic            carry_i,
  output logic      [7:0]      result_o,
  output logic                 carry_o,
  output logic                 nibble_carry_flag_o,
  output logic                 zero_o
);

  logic [8:0] diff;
  logic [4:0] nib_diff;

  always_comb begin
    diff     = {1'b0, literal_i} - {1'b0, acc_i};
    nib_diff = {1'b0, literal_i[3:0]} - {1'b0, acc_i[3:0]};
    result_o            = file_i;
    carry_o             = carry_i;
    nibble_carry_flag_o = 1'b0;
    zero_o              = 1'b0;
    unique case (rss_op_t'(op_i))
      RSS_OP_ROTATE_LEFT_THROUGH_CARRY: begin
        result_o = {file_i[6:0], carry_i};
        carry_o  = file_i[7];
      end
      RSS_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        result_o = {carry_i, file_i[7:1]};
        carry_o  = file_i[0];
      end
      RSS_OP_LITERAL_MINUS_ACCUMULATOR: begin
        // A borrow out of the 9-bit difference means the accumulator was larger.
        result_o            = diff[7:0];
        carry_o             = ~diff[8];
        nibble_carry_flag_o = ~nib_diff[4];
        zero_o              = (diff[7:0] == BYTE_ZERO);
      end
      default: begin
        result_o = file_i;
      end
    endcase
  end

endmodule

/* verif/rss_exec_properties.sv */
// Concurrent checks on the ports of the execution block.
`timescale 1ns/1ps
module rss_exec_chk
  import rss_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [ADR_W-1:0]  adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  input wire logic              wake_i,
  input wire logic              osc_run_o,
  input wire logic              asleep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  logic sleep_cmd;
  assign req = cyc_i && stb_i && !ack_o;
  assign sleep_cmd = req && we_i && adr_i[7:2] == OFS_CMD[7:2] && sel_i[1:0] == 2'b11
                     && dat_i[15:13] == RSS_OP_SLEEP && !asleep_o;
  chk_ack_answer: assert property (req |=> ack_o)
    else $error("request not answered in one cycle");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  chk_sleep_entry: assert property (sleep_cmd |-> ##2 asleep_o)
    else $error("sleep command did not enter sleep");
  chk_osc_stop: assert property (osc_run_o == !asleep_o)
    else $error("oscillator state disagrees with sleep state");
  chk_wake_cause: assert property ($fell(asleep_o) |-> $past(wake_i, 2))
    else $error("sleep left without a wake request");
  chk_unmapped_zero: assert property (req && !we_i && adr_i[7:5] == 3'b001 |=> dat_o == 32'h0)
    else $error("unmapped read returned nonzero data");
  chk_dat_hold: assert property (!(cyc_i && stb_i && !we_i) |=> $stable(dat_o))
    else $error("read data changed without a read");
  cover property (sleep_cmd);
  cover property ($fell(asleep_o));
  cover property (ack_o && !we_i);
endmodule

bind rss_exec rss_exec_chk rss_exec_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .wake_i, .osc_run_o, .asleep_o);

/* verif/tb.sv */
// Self-checking testbench for the execution block.
`timescale 1ns/1ps
module tb
  import rss_pkg::*;
;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, wake_i = 0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o, osc_run_o, asleep_o;
  int          error_cnt = 0, tests_run = 0;
  logic [31:0] exp_q[$];
  logic [7:0]  acc, f, lit, res;
  logic [3:0]  k;
  logic        c, dc, z, pd;
  rss_op_t     op;
  always #50 clk_i = ~clk_i;
  rss_exec rss_exec_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .wake_i, .osc_run_o, .asleep_o);
  task cmp32(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cmp1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, 16'h0, d, 4'hF};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 16'h0);
  endtask
  function automatic logic [7:0] stat();
    return {3'h0, 1'b1, pd, z, dc, c};
  endfunction
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) cmp32(dat_o, exp_q.pop_front());
  end
  task wrap_up;
    if (exp_q.size() != 0) error_cnt++;
    $display("errors=%0d compares=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(100 * 5000);
    error_cnt++;
    wrap_up;
  end
  initial begin
    void'($urandom(14));
    {pd, c, dc, z} = 4'b1000;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_STATUS, stat());
    rd(OFS_ACC, 8'h00);
    rd(8'h20, 8'h00);
    for (int i = 0; i < 8; i++) begin
      {acc, f, k, z, dc, c} = 23'($urandom);
      if (i < 2) f = i[0] ? 8'h01 : 8'h80;
      op = i[0] ? RSS_OP_ROTATE_RIGHT_THROUGH_CARRY : RSS_OP_ROTATE_LEFT_THROUGH_CARRY;
      wr(OFS_FILE_BASE + {k, 2'b00}, {8'h0, f});
      wr(OFS_ACC, {8'h0, acc});
      wr(OFS_STATUS, {11'h0, z, dc, c});
      wr(OFS_CMD, {op, i[1], k, 8'h00});
      if (i[0]) {res, c} = {c, f};
      else {c, res} = {f, c};
      if (!i[1]) acc = res;
      rd(OFS_ACC, acc);
      rd(OFS_FILE_BASE + {k, 2'b00}, i[1] ? res : f);
      rd(OFS_STATUS, stat());
    end
    for (int i = 0; i < 8; i++) begin
      {acc, lit} = 16'($urandom);
      if (i == 0) acc = lit;
      if (i == 1) acc = lit + 8'h01;
      if (i == 2) {acc, lit} = 16'h0;
      res = lit - acc;
      {c, dc, z} = {acc <= lit, acc[3:0] <= lit[3:0], res == 8'h00};
      wr(OFS_ACC, {8'h0, acc});
      wr(OFS_CMD, {RSS_OP_LITERAL_MINUS_ACCUMULATOR, 5'h0, lit});
      acc = res;
      rd(OFS_ACC, acc);
      rd(OFS_STATUS, stat());
    end
    wr(OFS_CMD, {3'h5, 5'h0, 8'hAA});
    rd(OFS_ACC, acc);
    rd(OFS_STATUS, stat());
    repeat (300) @(posedge clk_i);
    wr(OFS_CMD, {RSS_OP_SLEEP, 13'h0});
    pd = 1'b0;
    @(negedge clk_i);
    cmp1(asleep_o, 1'b1);
    cmp1(osc_run_o, 1'b0);
    rd(OFS_STATUS, stat());
    rd(OFS_WDOG, WDOG_CLEAR);
    rd(OFS_PRESC, PRESC_CLEAR);
    rd(OFS_STATE, 8'h01);
    wr(OFS_CMD, {RSS_OP_LITERAL_MINUS_ACCUMULATOR, 5'h0, 8'h55});
    rd(OFS_ACC, acc);
    wake_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    wake_i <= 1'b0;
    cmp1(asleep_o, 1'b0);
    cmp1(osc_run_o, 1'b1);
    rd(OFS_STATE, 8'h00);
    @(negedge clk_i);
    wrap_up;
  end
endmodule
